// file: logic/nsl_consts.vh
// What this block does
// - ready state: green led triple flash repeating about once per second
// - managing node ready: keep communicating, drop all received process data
// - controlled node ready: transmit mapped process data, ignore received cyclic data
// - controlled node ready: red led lights when managing node has failed
// - operational: green led steady on, mapping applied, received data evaluated
// - stopped: green led blinks at about 2.5 Hz
// - a managing node never enters the stopped state
// - controlled node stopped: no output data, no input data provided
// - stopped entered or left only on managing node command
// - system stop error: four red on-phases, each 150 ms or 600 ms
// - error code repeats forever with 2 s pause between repetitions
// - ram error code: short short short long, then pause
// - hardware error code: long short short long, then pause
// - controlled node goes pre-operational-2 to ready only on command once configured
`ifndef NSL_CONSTS_VH
`define NSL_CONSTS_VH

`define NSL_CLK_HZ 25000000
`define NSL_TICK_DIV 25000
`define NSL_SHORT_MS 150
`define NSL_LONG_MS 600
`define NSL_PAUSE_MS 2000
`define NSL_FLASH_PERIOD_MS 1000
`define NSL_BLINK_HALF_MS 200
`define NSL_MS_W 11
// states of the node
`define NSL_ST_PREOP2 3'h0
`define NSL_ST_READY 3'h1
`define NSL_ST_OPER 3'h2
`define NSL_ST_STOP 3'h3
`define NSL_ST_OTHER 3'h4
// commands from the managing node
`define NSL_CMD_NONE 3'h0
`define NSL_CMD_READY 3'h1
`define NSL_CMD_OPER 3'h2
`define NSL_CMD_STOP 3'h3
`define NSL_CMD_LEAVE_STOP 3'h4
`define NSL_CMD_PREOP2 3'h5
// error code patterns, bit 3 first phase, 1 = long
`define NSL_CODE_RAM 4'h1
`define NSL_CODE_HW 4'h9
`define NSL_PHASES 3'h4

`endif

// file: logic/nsl_err_coder.v
`timescale 1ns/10ps
`include "nsl_consts.vh"
// ==========
// red error code sequencer
module nsl_err_coder #(
  parameter MS_W = `NSL_MS_W
) (
  sys_clk, // clock
  rst, // sync reset
  clkEn, // clock enable
  msTick, // one-cycle ms pulse
  active, // error code active
  code, // 4-phase pattern, 1 = long
  redOn // red on during error
);
  input wire sys_clk;
  input wire rst;
  input wire clkEn;
  input wire msTick;
  input wire active;
  input wire [3:0] code;
  output reg redOn;

  localparam S_IDLE = 2'h0;
  localparam S_ON = 2'h1;
  localparam S_GAP = 2'h2;
  localparam S_PAUSE = 2'h3;
  localparam [MS_W-1:0] SHORT_LEN = `NSL_SHORT_MS;
  localparam [MS_W-1:0] LONG_LEN = `NSL_LONG_MS;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [MS_W-1:0] msCnt_reg;
  reg [MS_W-1:0] msCnt_next;
  reg [2:0] phase_reg;
  reg [2:0] phase_next;
  wire [MS_W-1:0] onLen;
  wire curLong;

  assign curLong = code[3 - phase_reg[1:0]];
  assign onLen = curLong ? LONG_LEN : SHORT_LEN;

  always @* begin
    state_next = state_reg;
    msCnt_next = msCnt_reg;
    phase_next = phase_reg;
    if (!active) begin
      state_next = S_IDLE;
      msCnt_next = {MS_W{1'b0}};
      phase_next = 3'h0;
    end else if (msTick || state_reg == S_IDLE) begin
      msCnt_next = msCnt_reg + 1'b1;
      case (state_reg)
        S_IDLE: begin
          state_next = S_ON;
          msCnt_next = {MS_W{1'b0}};
          phase_next = 3'h0;
        end
        S_ON: begin
          if (msCnt_reg == onLen - 1'b1) begin
            msCnt_next = {MS_W{1'b0}};
            phase_next = phase_reg + 1'b1;
            // last phase goes straight to the long pause
            state_next = (phase_reg == `NSL_PHASES - 1'b1) ? S_PAUSE : S_GAP;
          end
        end
        S_GAP: begin
          if (msCnt_reg == `NSL_SHORT_MS - 1) begin
            msCnt_next = {MS_W{1'b0}};
            state_next = S_ON;
          end
        end
        S_PAUSE: begin
          if (msCnt_reg == `NSL_PAUSE_MS - 1) begin
            msCnt_next = {MS_W{1'b0}};
            phase_next = 3'h0;
            state_next = S_ON;
          end
        end
        default: state_next = S_IDLE;
      endcase
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= S_IDLE;
      msCnt_reg <= {MS_W{1'b0}};
      phase_reg <= 3'h0;
      redOn <= 1'b0;
    end else if (clkEn) begin
      state_reg <= state_next;
      msCnt_reg <= msCnt_next;
      phase_reg <= phase_next;
      redOn <= (state_next == S_ON);
    end
  end
endmodule

// file: logic/nsl_status_led.v
`timescale 1ns/10ps
`include "nsl_consts.vh"
// ==========
// node status and led coder
module nsl_status_led #(
  parameter TICK_DIV = `NSL_TICK_DIV,
  parameter MS_W = `NSL_MS_W
) (
  sys_clk, // 25 MHz clock
  rst, // sync reset, active high
  clkEn, // freezes all state when low
  isManager, // 1 = managing node role
  configured, // node configuration complete
  cmdValid, // command from managing node, pulse
  cmdCode, // command code
  managerFail, // managing node lost
  ramErr, // system stop: ram error
  hwErr, // system stop: hardware error
  nodeState, // current node state
  greenLed, // green status led
  redLed, // red error led
  txEnable, // transmit process data
  txMapped, // transmitted data follows mapping
  rxEvaluate, // evaluate received cyclic data
  inputProvide, // provide input data to application
  outputEnable, // drive output data
  commActive // cyclic/async communication running
);
  input wire sys_clk;
  input wire rst;
  input wire clkEn;
  input wire isManager;
  input wire configured;
  input wire cmdValid;
  input wire [2:0] cmdCode;
  input wire managerFail;
  input wire ramErr;
  input wire hwErr;
  output reg [2:0] nodeState;
  output reg greenLed;
  output reg redLed;
  output reg txEnable;
  output reg txMapped;
  output reg rxEvaluate;
  output reg inputProvide;
  output reg outputEnable;
  output reg commActive;

  // ==========
  // millisecond timebase
  reg [15:0] divCnt_reg;
  reg msTick;
  always @(posedge sys_clk) begin
    if (rst) begin
      divCnt_reg <= 16'h0000;
      msTick <= 1'b0;
    end else if (clkEn) begin
      msTick <= (divCnt_reg == TICK_DIV - 1);
      if (divCnt_reg == TICK_DIV - 1)
        divCnt_reg <= 16'h0000;
      else
        divCnt_reg <= divCnt_reg + 16'h0001;
    end
  end

  // ==========
  // node state machine
  reg [2:0] state_next;
  always @* begin
    state_next = nodeState;
    if (cmdValid) begin
      case (cmdCode)
        `NSL_CMD_READY: begin
          // only a configured node in preop2 may advance
          if (nodeState == `NSL_ST_PREOP2 && configured)
            state_next = `NSL_ST_READY;
        end
        `NSL_CMD_OPER: begin
          if (nodeState == `NSL_ST_READY)
            state_next = `NSL_ST_OPER;
        end
        `NSL_CMD_STOP: begin
          if (!isManager)
            state_next = `NSL_ST_STOP;
        end
        `NSL_CMD_LEAVE_STOP: begin
          if (nodeState == `NSL_ST_STOP)
            state_next = `NSL_ST_PREOP2;
        end
        `NSL_CMD_PREOP2: state_next = `NSL_ST_PREOP2;
        default: state_next = nodeState;
      endcase
    end
    if (isManager && state_next == `NSL_ST_STOP)
      state_next = `NSL_ST_PREOP2;
  end

  // ==========
  // green patterns, one shared ms counter
  reg [MS_W-1:0] patCnt_reg;
  wire [MS_W-1:0] patCnt_next;
  wire blinkWrap;
  wire flashWrap;
  reg green_next;
  assign blinkWrap = (nodeState == `NSL_ST_STOP) &&
                     (patCnt_reg == `NSL_BLINK_HALF_MS * 2 - 1);
  assign flashWrap = (patCnt_reg == `NSL_FLASH_PERIOD_MS - 1);
  assign patCnt_next = (state_next != nodeState || blinkWrap || flashWrap) ?
                       {MS_W{1'b0}} : patCnt_reg + 1'b1;

  // three flashes, equal on and off gaps, rest of second dark
  function flashOn;
    input [MS_W-1:0] t;
    begin
      flashOn = (t < `NSL_SHORT_MS) ||
                (t >= 2 * `NSL_SHORT_MS && t < 3 * `NSL_SHORT_MS) ||
                (t >= 4 * `NSL_SHORT_MS && t < 5 * `NSL_SHORT_MS);
    end
  endfunction

  always @* begin
    case (nodeState)
      `NSL_ST_READY: green_next = flashOn(patCnt_reg);
      `NSL_ST_OPER: green_next = 1'b1;
      `NSL_ST_STOP: green_next = (patCnt_reg < `NSL_BLINK_HALF_MS);
      default: green_next = 1'b0;
    endcase
  end

  // ==========
  // system stop error code
  wire errActive;
  wire [3:0] errCode;
  wire errRed;
  assign errActive = ramErr | hwErr;
  // hardware error wins when both are flagged
  assign errCode = hwErr ? `NSL_CODE_HW : `NSL_CODE_RAM;

  nsl_err_coder #(
    .MS_W(MS_W)
  ) uErr (
    .sys_clk(sys_clk),
    .rst(rst),
    .clkEn(clkEn),
    .msTick(msTick),
    .active(errActive),
    .code(errCode),
    .redOn(errRed)
  );

  // ==========
  // registers and data path controls
  always @(posedge sys_clk) begin
    if (rst) begin
      nodeState <= `NSL_ST_PREOP2;
      patCnt_reg <= {MS_W{1'b0}};
      greenLed <= 1'b0;
      redLed <= 1'b0;
      txEnable <= 1'b0;
      txMapped <= 1'b0;
      rxEvaluate <= 1'b0;
      inputProvide <= 1'b0;
      outputEnable <= 1'b0;
      commActive <= 1'b0;
    end else if (clkEn) begin
      nodeState <= state_next;
      if (msTick || state_next != nodeState)
        patCnt_reg <= patCnt_next;
      greenLed <= green_next;
      if (errActive)
        redLed <= errRed;
      else
        redLed <= !isManager && managerFail &&
                  nodeState == `NSL_ST_READY;
      case (state_next)
        `NSL_ST_READY: begin
          commActive <= 1'b1;
          txEnable <= !isManager;
          txMapped <= !isManager;
          rxEvaluate <= 1'b0;
          inputProvide <= 1'b0;
          outputEnable <= 1'b1;
        end
        `NSL_ST_OPER: begin
          commActive <= 1'b1;
          txEnable <= 1'b1;
          txMapped <= 1'b1;
          rxEvaluate <= 1'b1;
          inputProvide <= 1'b1;
          outputEnable <= 1'b1;
        end
        `NSL_ST_STOP: begin
          commActive <= 1'b1;
          txEnable <= 1'b0;
          txMapped <= 1'b0;
          rxEvaluate <= 1'b0;
          inputProvide <= 1'b0;
          outputEnable <= 1'b0;
        end
        default: begin
          commActive <= 1'b1;
          txEnable <= 1'b0;
          txMapped <= 1'b0;
          rxEvaluate <= 1'b0;
          inputProvide <= 1'b0;
          outputEnable <= 1'b0;
        end
      endcase
    end
  end
endmodule

// file: tb/nsl_mgr_model.sv
`timescale 1ns/10ps
// ==========
// managing node: one-cycle command strobes
module nsl_mgr_model (
  input wire sys_clk, // clock
  input wire go, // send request
  input wire [2:0] code, // command to send
  output reg cmdValid, // strobe to node
  output reg [2:0] cmdCode // command code
);
  initial cmdValid = 1'b0;
  initial cmdCode = 3'h0;
  // only this side ever commands a state change
  always @(posedge sys_clk) begin
    cmdValid <= go;
    cmdCode <= go ? code : 3'h0;
  end
endmodule

// file: tb/nsl_status_led_asserts.sv
`timescale 1ns/10ps
// ==========
// status led checker
module nsl_led_chk #(
  parameter TICK_DIV = 4
) (
  input wire sys_clk,
  input wire rst,
  input wire clkEn,
  input wire isManager,
  input wire configured,
  input wire cmdValid,
  input wire [2:0] cmdCode,
  input wire managerFail,
  input wire ramErr,
  input wire hwErr,
  input wire [2:0] nodeState,
  input wire greenLed,
  input wire redLed,
  input wire txEnable,
  input wire txMapped,
  input wire rxEvaluate,
  input wire inputProvide,
  input wire outputEnable,
  input wire commActive
);
  localparam int SH = 150 * TICK_DIV;
  localparam int LG = 600 * TICK_DIV;
  int onLen;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // tick phase is unknown, so allow one tick either way
  always @(posedge sys_clk) begin
    onLen <= redLed ? onLen + 1 : 0;
  end
  sequence s_readyCmd;
    clkEn && cmdValid && cmdCode == 3'h1 && nodeState == 3'h0 && configured;
  endsequence
  sequence s_mnStop;
    cmdValid && cmdCode == 3'h3 && isManager && nodeState != 3'h3;
  endsequence
  property p_readyGo;
    s_readyCmd |=> nodeState == 3'h1;
  endproperty
  property p_mnNoStop;
    s_mnStop |=> nodeState != 3'h3;
  endproperty
  property p_stopByCmd;
    $rose(nodeState == 3'h3) |-> $past(cmdValid) && $past(cmdCode) == 3'h3;
  endproperty
  property p_stopQuiet;
    nodeState == 3'h3 |-> !outputEnable && !inputProvide;
  endproperty
  property p_cnReady;
    !isManager && nodeState == 3'h1 |-> txEnable && txMapped && !rxEvaluate;
  endproperty
  property p_mnReady;
    isManager && nodeState == 3'h1 |-> commActive && !rxEvaluate;
  endproperty
  property p_operOn;
    (nodeState == 3'h2)[*2] |-> greenLed && rxEvaluate;
  endproperty
  property p_failRed;
    (!isManager && nodeState == 3'h1 && managerFail && !ramErr && !hwErr)[*3] |-> redLed;
  endproperty
  property p_phaseLen;
    $fell(redLed) && (ramErr || hwErr) |->
      onLen inside {[SH - TICK_DIV:SH + TICK_DIV], [LG - TICK_DIV:LG + TICK_DIV]};
  endproperty
  a_readyGo: assert property (p_readyGo) else $error("ready command not taken");
  a_mnNoStop: assert property (p_mnNoStop) else $error("manager stopped");
  a_stopByCmd: assert property (p_stopByCmd) else $error("stop without command");
  a_stopQuiet: assert property (p_stopQuiet) else $error("data while stopped");
  a_cnReady: assert property (p_cnReady) else $error("node ready data wrong");
  a_mnReady: assert property (p_mnReady) else $error("manager ready data wrong");
  a_operOn: assert property (p_operOn) else $error("operational led or data wrong");
  a_failRed: assert property (p_failRed) else $error("no red on manager loss");
  a_phaseLen: assert property (p_phaseLen) else $error("bad red phase length");
endmodule
bind nsl_status_led nsl_led_chk #(.TICK_DIV(TICK_DIV)) chk_u (
  .sys_clk(sys_clk),
  .rst(rst),
  .clkEn(clkEn),
  .isManager(isManager),
  .configured(configured),
  .cmdValid(cmdValid),
  .cmdCode(cmdCode),
  .managerFail(managerFail),
  .ramErr(ramErr),
  .hwErr(hwErr),
  .nodeState(nodeState),
  .greenLed(greenLed),
  .redLed(redLed),
  .txEnable(txEnable),
  .txMapped(txMapped),
  .rxEvaluate(rxEvaluate),
  .inputProvide(inputProvide),
  .outputEnable(outputEnable),
  .commActive(commActive)
);

// file: tb/nsl_status_led_bench.sv
`timescale 1ns/10ps
// ==========
// status led bench
module nsl_status_led_bench;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic clkEn = 1'b1;
  logic isManager = 1'b0;
  logic configured = 1'b0;
  logic managerFail = 1'b0;
  logic ramErr = 1'b0;
  logic hwErr = 1'b0;
  logic go = 1'b0;
  logic [2:0] code = 3'h0;
  logic cmdValid;
  logic [2:0] cmdCode;
  logic [2:0] nodeState;
  logic greenLed, redLed, txEnable, txMapped, rxEvaluate;
  logic inputProvide, outputEnable, commActive;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  // short tick keeps the 2 s pause near 8000 cycles
  nsl_status_led #(.TICK_DIV(4)) dut_u (
    .sys_clk(sys_clk),
    .rst(rst),
    .clkEn(clkEn),
    .isManager(isManager),
    .configured(configured),
    .cmdValid(cmdValid),
    .cmdCode(cmdCode),
    .managerFail(managerFail),
    .ramErr(ramErr),
    .hwErr(hwErr),
    .nodeState(nodeState),
    .greenLed(greenLed),
    .redLed(redLed),
    .txEnable(txEnable),
    .txMapped(txMapped),
    .rxEvaluate(rxEvaluate),
    .inputProvide(inputProvide),
    .outputEnable(outputEnable),
    .commActive(commActive)
  );
  nsl_mgr_model mgr_u (.sys_clk(sys_clk), .go(go), .code(code), .cmdValid(cmdValid),
    .cmdCode(cmdCode));
  always #20 sys_clk = ~sys_clk;
  task wrap_up;
    begin
      $display("checks %0d bad %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 80000) begin
      bad_count++;
      wrap_up;
    end
  end
  task check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    begin
      check_count++;
      if (got !== exp) begin
        bad_count++;
        $display("BAD %s exp %0h got %0h", nm, exp, got);
      end
    end
  endtask
  task restart(input logic mgr);
    begin
      @(posedge sys_clk);
      rst <= 1'b1;
      isManager <= mgr;
      configured <= 1'b1;
      managerFail <= 1'b0;
      ramErr <= 1'b0;
      hwErr <= 1'b0;
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      #1;
    end
  endtask
  task send(input logic [2:0] c);
    begin
      @(posedge sys_clk);
      go <= 1'b1;
      code <= c;
      @(posedge sys_clk);
      go <= 1'b0;
      @(posedge sys_clk);
      #1;
    end
  endtask
  task rises(input int n, output int r);
    logic prev;
    begin
      r = 0;
      prev = greenLed;
      repeat (n) begin
        @(posedge sys_clk);
        if (greenLed === 1'b1 && prev !== 1'b1)
          r++;
        prev = greenLed;
      end
    end
  endtask
  task t_cn;
    int r;
    begin
      restart(1'b0);
      check("reset state", 3'h0, nodeState);
      @(posedge sys_clk);
      configured <= 1'b0;
      send(3'h2);
      check("oper refused", 3'h0, nodeState);
      send(3'h1);
      check("ready unconfigured", 3'h0, nodeState);
      @(posedge sys_clk);
      configured <= 1'b1;
      send(3'h1);
      check("ready", 3'h1, nodeState);
      check("cn tx", 1'b1, txEnable && txMapped && !rxEvaluate);
      // 900 ms window: all three flashes, but not the next period's first
      rises(3600, r);
      check("triple flash", 3'h3, r);
      @(posedge sys_clk);
      managerFail <= 1'b1;
      repeat (3) @(posedge sys_clk);
      #1;
      check("fail red", 1'b1, redLed);
      @(posedge sys_clk);
      managerFail <= 1'b0;
      send(3'h2);
      repeat (3) @(posedge sys_clk);
      #1;
      check("oper green", 1'b1, greenLed && rxEvaluate);
      send(3'h3);
      check("stopped", 3'h3, nodeState);
      check("stop data", 1'b0, outputEnable || inputProvide);
      // green was on in operational, so first rise comes after one period
      rises(4000, r);
      check("blink", 3'h2, r);
      send(3'h4);
      check("leave stop", 3'h0, nodeState);
      $display("test cn done");
    end
  endtask
  task t_mn;
    begin
      restart(1'b1);
      @(posedge sys_clk);
      clkEn <= 1'b0;
      send(3'h1);
      check("frozen", 3'h0, nodeState);
      @(posedge sys_clk);
      clkEn <= 1'b1;
      send(3'h1);
      check("mn ready", 3'h1, nodeState);
      check("mn comm", 1'b1, commActive && !rxEvaluate);
      send(3'h3);
      check("mn stop refused", 3'h1, nodeState);
      $display("test mn done");
    end
  endtask
  task t_err(input logic hw, input logic [3:0] exp);
    logic [3:0] pat;
    int on, off;
    begin
      restart(1'b0);
      @(posedge sys_clk);
      ramErr <= 1'b1;
      hwErr <= hw;
      while (redLed !== 1'b1) @(posedge sys_clk);
      for (int i = 0; i < 4; i++) begin
        on = 0;
        off = 0;
        while (redLed === 1'b1) begin
          on++;
          @(posedge sys_clk);
        end
        while (redLed !== 1'b1) begin
          off++;
          @(posedge sys_clk);
        end
        pat[3 - i] = on > 1500;
      end
      check("error code", exp, pat);
      check("pause", 1'b1, off > 7990 && off < 8010);
      $display("test err done");
    end
  endtask
  initial begin
    t_cn;
    t_mn;
    t_err(1'b0, 4'h1);
    t_err(1'b1, 4'h9);
    wrap_up;
  end
endmodule
